// ===== hw/digital_tracking_loop_cfg_pkg.sv
// Overview of operation
// - 4-bit coarse code n gives +/-(2^(n+1)-1) UI; codes 1100-1111 give +/-8191 UI.
// - coarse limit register resets to 1110 0101: enables set, +/-63 UI tracked.
// - with screen enable bit 7 set, edges outside 5% window are ignored.
// - noise window register is read/write, resets to 0000 0110, bits 6:0 do nothing.
// - coarse enable set: phase loss when error exceeds limit; clear: never from here.
// - multi-cycle response clear clamps error to +/-1 UI; set allows +/-8191 UI.
package digital_tracking_loop_cfg_pkg;

  // register port
  localparam int          REG_AW            = 7;
  localparam int          REG_DW            = 8;
  localparam logic [6:0]  COARSE_LIMIT_ADDR = 7'h74;
  localparam logic [6:0]  NOISE_WINDOW_ADDR = 7'h75;
  localparam logic [7:0]  COARSE_RESET      = 8'he5;
  localparam logic [7:0]  NOISE_RESET       = 8'h06;

  // field positions
  localparam int          PHASELOSS_EN_BIT  = 7;
  localparam int          WIDE_RANGE_BIT    = 6;
  localparam int          MULTI_CYCLE_BIT   = 5;
  localparam int          LIMIT_MSB         = 3;
  localparam int          SCREEN_EN_BIT     = 7;

  // phase error format: signed, FRAC_BITS fractional bits of one UI
  localparam int          ERR_W             = 24;
  localparam int          FRAC_BITS         = 8;
  localparam logic [3:0]  MAX_DOUBLING_CODE = 4'hb;
  localparam logic [13:0] SAT_RANGE_UI      = 14'h1fff;
  localparam logic [23:0] ONE_UI            = 24'h000100;

  // screening window: 5 percent of the expected period
  localparam int          WINDOW_PCT        = 5;
  localparam int          WINDOW_DIV        = 100 / WINDOW_PCT;

  // tracking span in whole UI for a coarse code
  function automatic logic [13:0] limit_ui(input logic [3:0] code);
    logic [14:0] span;
    span = 15'h0001;
    if (code > MAX_DOUBLING_CODE) begin
      limit_ui = SAT_RANGE_UI;
    end else begin
      span = 15'((15'h0002 << code) - 15'h0001);
      limit_ui = span[13:0];
    end
  endfunction : limit_ui

  // magnitude of a signed phase error
  function automatic logic [ERR_W-1:0] abs_err(input logic signed [ERR_W-1:0] e);
    abs_err = e[ERR_W-1] ? ERR_W'(-e) : ERR_W'(e);
  endfunction : abs_err

  // clamp a signed phase error to +/-lim
  function automatic logic signed [ERR_W-1:0] sat_err(input logic signed [ERR_W-1:0] e,
                                                       input logic [ERR_W-1:0]        lim);
    if (abs_err(e) <= lim) begin
      sat_err = e;
    end else if (e[ERR_W-1]) begin
      sat_err = ERR_W'(-$signed(lim));
    end else begin
      sat_err = $signed(lim);
    end
  endfunction : sat_err

endpackage : digital_tracking_loop_cfg_pkg

// ===== hw/edge_screen.sv
module edge_screen #(
  parameter int CNT_W = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             ref_edge,
  input  wire logic [CNT_W-1:0] ref_period,
  output logic                  edge_accept,
  output logic                  edge_reject
);
  import digital_tracking_loop_cfg_pkg::*;

  localparam int WW = CNT_W + 6;

  logic [CNT_W-1:0] since_q, since_d;
  logic             synced_q, synced_d;
  logic             accept_q, accept_d;
  logic             reject_q, reject_d;
  logic [CNT_W-1:0] diff;
  logic             in_window;
  logic             overdue;

  // window test in integer form: 20*|since-period| <= period avoids a divider
  always_comb begin
    diff      = (since_q > ref_period) ? since_q - ref_period : ref_period - since_q;
    in_window = (WW'(diff) * WW'(WINDOW_DIV)) <= WW'(ref_period);
    overdue   = (WW'(since_q) * WW'(WINDOW_DIV)) >
                (WW'(ref_period) * WW'(WINDOW_DIV + 1));
  end

  // next state: a missed edge moves the expected time on by one period
  always_comb begin
    since_d  = since_q;
    synced_d = synced_q;
    accept_d = 1'b0;
    reject_d = 1'b0;
    if (ref_edge && (!enable || !synced_q || in_window)) begin
      accept_d = 1'b1;
      synced_d = 1'b1;
      since_d  = CNT_W'(1);
    end else begin
      reject_d = ref_edge;
      if (overdue) begin
        since_d = since_q - ref_period + CNT_W'(1);
      end else if (since_q != {CNT_W{1'b1}}) begin
        since_d = since_q + CNT_W'(1);
      end
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_q  <= '0;
      synced_q <= 1'b0;
      accept_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      since_q  <= since_d;
      synced_q <= synced_d;
      accept_q <= accept_d;
      reject_q <= reject_d;
    end
  end

  assign edge_accept = accept_q;
  assign edge_reject = reject_q;

  chk_screen_pass_off : assert property (@(posedge clk) disable iff (!rst_n)
    (ref_edge && !enable) |=> edge_accept) else $error("edge dropped while screen off");

  chk_screen_outside : assert property (@(posedge clk) disable iff (!rst_n)
    (ref_edge && enable && synced_q && !in_window) |=> (edge_reject && !edge_accept))
    else $error("edge outside window was accepted");

  chk_screen_inside : assert property (@(posedge clk) disable iff (!rst_n)
    (ref_edge && enable && synced_q && in_window) |=> (edge_accept && !edge_reject))
    else $error("edge inside window was dropped");

  chk_screen_idle : assert property (@(posedge clk) disable iff (!rst_n)
    !ref_edge |=> (!edge_accept && !edge_reject)) else $error("verdict without an edge");

endmodule : edge_screen

// ===== hw/digital_tracking_loop_phase_limits.sv
module digital_tracking_loop_phase_limits #(
  parameter int PERIOD_W = 16
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  input  wire logic [digital_tracking_loop_cfg_pkg::REG_AW-1:0]        reg_addr,
  input  wire logic [digital_tracking_loop_cfg_pkg::REG_DW-1:0]        reg_wdata,
  output logic      [digital_tracking_loop_cfg_pkg::REG_DW-1:0]        reg_rdata,
  input  wire logic signed [digital_tracking_loop_cfg_pkg::ERR_W-1:0]  phase_err,
  output logic                                        phase_loss,
  output logic signed [digital_tracking_loop_cfg_pkg::ERR_W-1:0]       loop_phase_err,
  input  wire logic                                   ref_edge,
  input  wire logic [PERIOD_W-1:0]                    ref_period,
  output logic                                        edge_accept,
  output logic                                        edge_reject,
  output logic                                        wide_range_en
);
  import digital_tracking_loop_cfg_pkg::*;

  logic [REG_DW-1:0]        coarse_cfg_q, coarse_cfg_d;
  logic [REG_DW-1:0]        noise_cfg_q, noise_cfg_d;
  logic [REG_DW-1:0]        rdata_q, rdata_d;
  logic                     loss_q, loss_d;
  logic signed [ERR_W-1:0]  loop_err_q, loop_err_d;
  logic                     up_q;
  logic [13:0]              limit;
  logic [ERR_W-1:0]         limit_fine;
  logic [ERR_W-1:0]         err_mag;
  logic                     multi_cycle_response;
  logic                     loss_enable;
  logic                     edge_screen_enable;

  // field extraction
  always_comb begin
    limit                = limit_ui(coarse_cfg_q[LIMIT_MSB:0]);
    limit_fine           = ERR_W'({limit, {FRAC_BITS{1'b0}}});
    err_mag              = abs_err(phase_err);
    multi_cycle_response = coarse_cfg_q[MULTI_CYCLE_BIT];
    loss_enable          = coarse_cfg_q[PHASELOSS_EN_BIT];
    edge_screen_enable   = noise_cfg_q[SCREEN_EN_BIT];
  end

  // register port: writes land on the next edge, reads answer one cycle later
  always_comb begin
    coarse_cfg_d = coarse_cfg_q;
    noise_cfg_d  = noise_cfg_q;
    rdata_d      = rdata_q;
    if (reg_wr) begin
      case (reg_addr)
        COARSE_LIMIT_ADDR: coarse_cfg_d = reg_wdata;
        NOISE_WINDOW_ADDR: noise_cfg_d  = reg_wdata;   // low bits kept, unused
        default:           coarse_cfg_d = coarse_cfg_q;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        COARSE_LIMIT_ADDR: rdata_d = coarse_cfg_q;
        NOISE_WINDOW_ADDR: rdata_d = noise_cfg_q;
        default:           rdata_d = '0;               // unmapped reads as zero
      endcase
    end
  end

  // phase loss and loop error; the clamp keeps a +/-1 UI loop from seeing cycle slips
  always_comb begin
    loss_d = loss_enable && (err_mag > limit_fine);
    if (multi_cycle_response) begin
      loop_err_d = sat_err(phase_err, ERR_W'({SAT_RANGE_UI, {FRAC_BITS{1'b0}}}));
    end else begin
      loop_err_d = sat_err(phase_err, ONE_UI);
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse_cfg_q <= COARSE_RESET;
      noise_cfg_q  <= NOISE_RESET;
      rdata_q      <= '0;
      loss_q       <= 1'b0;
      loop_err_q   <= '0;
      up_q         <= 1'b0;
    end else begin
      coarse_cfg_q <= coarse_cfg_d;
      noise_cfg_q  <= noise_cfg_d;
      rdata_q      <= rdata_d;
      loss_q       <= loss_d;
      loop_err_q   <= loop_err_d;
      up_q         <= 1'b1;
    end
  end

  assign reg_rdata      = rdata_q;
  assign phase_loss     = loss_q;
  assign loop_phase_err = loop_err_q;
  assign wide_range_en  = coarse_cfg_q[WIDE_RANGE_BIT];

  // low-frequency reference edge screening
  edge_screen #(
    .CNT_W       (PERIOD_W)
  ) u_edge_screen (
    .clk         (clk),
    .rst_n       (rst_n),
    .enable      (edge_screen_enable),
    .ref_edge    (ref_edge),
    .ref_period  (ref_period),
    .edge_accept (edge_accept),
    .edge_reject (edge_reject)
  );

  // reset values and register access
  chk_reset_values : assert property (@(posedge clk) disable iff (!rst_n)
    !up_q |-> (coarse_cfg_q == 8'he5 && noise_cfg_q == 8'h06 && limit == 14'h003f))
    else $error("register reset value wrong");

  chk_noise_reset_off : assert property (@(posedge clk) disable iff (!rst_n)
    !up_q |-> !edge_screen_enable) else $error("screen enabled out of reset");

  chk_noise_write : assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 7'h75) |=> (noise_cfg_q == $past(reg_wdata)))
    else $error("noise window write lost");

  chk_coarse_write : assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && reg_addr == 7'h74) |=> (coarse_cfg_q == $past(reg_wdata)))
    else $error("coarse limit write lost");

  chk_noise_keep : assert property (@(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == 7'h75) |=> $stable(noise_cfg_q))
    else $error("noise window changed without a write");

  chk_coarse_keep : assert property (@(posedge clk) disable iff (!rst_n)
    !(reg_wr && reg_addr == 7'h74) |=> $stable(coarse_cfg_q))
    else $error("coarse limit changed without a write");

  // span decoding, one check per documented code
  chk_limit_base : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h0) |-> (limit == 14'h0001)) else $error("code 0 span wrong");

  chk_limit_code1 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h1) |-> (limit == 14'h0003)) else $error("code 1 span wrong");

  chk_limit_code2 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h2) |-> (limit == 14'h0007)) else $error("code 2 span wrong");

  chk_limit_code3 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h3) |-> (limit == 14'h000f)) else $error("code 3 span wrong");

  chk_limit_code4 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h4) |-> (limit == 14'h001f)) else $error("code 4 span wrong");

  chk_limit_code5 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h5) |-> (limit == 14'h003f)) else $error("code 5 span wrong");

  chk_limit_code6 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h6) |-> (limit == 14'h007f)) else $error("code 6 span wrong");

  chk_limit_code7 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h7) |-> (limit == 14'h00ff)) else $error("code 7 span wrong");

  chk_limit_code8 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h8) |-> (limit == 14'h01ff)) else $error("code 8 span wrong");

  chk_limit_code9 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'h9) |-> (limit == 14'h03ff)) else $error("code 9 span wrong");

  chk_limit_code10 : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'ha) |-> (limit == 14'h07ff)) else $error("code 10 span wrong");

  chk_limit_top : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:2] == 2'b11) |-> (limit == 14'h1fff)) else $error("top code span wrong");

  chk_limit_double : assert property (@(posedge clk) disable iff (!rst_n)
    (coarse_cfg_q[3:0] == 4'hb) |-> (limit == 14'h0fff)) else $error("code 11 span wrong");

  // loss detector
  chk_loss_disabled : assert property (@(posedge clk) disable iff (!rst_n)
    !loss_enable |=> !phase_loss) else $error("loss flagged while disabled");

  chk_loss_exceed : assert property (@(posedge clk) disable iff (!rst_n)
    (loss_enable && err_mag > limit_fine && $stable(coarse_cfg_q)) |=> phase_loss)
    else $error("loss missed beyond limit");

  chk_loss_within : assert property (@(posedge clk) disable iff (!rst_n)
    (loss_enable && err_mag <= limit_fine) |=> !phase_loss) else $error("loss inside limit");

  // loop error clamp
  chk_single_clamp : assert property (@(posedge clk) disable iff (!rst_n)
    !multi_cycle_response |=> (abs_err(loop_phase_err) <= 24'h000100))
    else $error("loop error beyond one UI");

  chk_single_pass : assert property (@(posedge clk) disable iff (!rst_n)
    (!multi_cycle_response && err_mag <= 24'h000100) |=> (loop_phase_err == $past(phase_err)))
    else $error("small error altered in single cycle mode");

  chk_single_sat : assert property (@(posedge clk) disable iff (!rst_n)
    (!multi_cycle_response && err_mag > 24'h000100) |=> (abs_err(loop_phase_err) == 24'h000100))
    else $error("large error not held at one UI");

  chk_multi_span : assert property (@(posedge clk) disable iff (!rst_n)
    (multi_cycle_response && err_mag <= 24'h1fff00) |=> (loop_phase_err == $past(phase_err)))
    else $error("multi cycle path altered error");

  chk_multi_sat : assert property (@(posedge clk) disable iff (!rst_n)
    (multi_cycle_response && err_mag > 24'h1fff00) |=> (abs_err(loop_phase_err) == 24'h1fff00))
    else $error("multi cycle error not held at full span");

  chk_reg_readback : assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && !reg_wr && reg_addr == 7'h75) |=> (reg_rdata == noise_cfg_q))
    else $error("noise window readback wrong");

  chk_coarse_readback : assert property (@(posedge clk) disable iff (!rst_n)
    (reg_rd && !reg_wr && reg_addr == 7'h74) |=> (reg_rdata == coarse_cfg_q))
    else $error("coarse limit readback wrong");

  chk_rdata_hold : assert property (@(posedge clk) disable iff (!rst_n)
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved without a read");

endmodule : digital_tracking_loop_phase_limits

// ===== testbench/tb_digital_tracking_loop_phase_limits.sv
module tb_digital_tracking_loop_phase_limits;
  timeunit 1ns;
  timeprecision 100ps;
  import digital_tracking_loop_cfg_pkg::*;

  logic                    clk;
  logic                    rst_n;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [REG_AW-1:0]       reg_addr;
  logic [REG_DW-1:0]       reg_wdata;
  logic [REG_DW-1:0]       reg_rdata;
  logic signed [ERR_W-1:0] phase_err;
  logic                    phase_loss;
  logic signed [ERR_W-1:0] loop_phase_err;
  logic                    ref_edge;
  logic [15:0]             ref_period;
  logic                    edge_accept;
  logic                    edge_reject;
  logic                    wide_range_en;
  int                      failures;
  int                      checks_done;
  int                      cycles;
  int                      lim;

  digital_tracking_loop_phase_limits #(.PERIOD_W(16)) dut_u (
    .clk            (clk),
    .rst_n          (rst_n),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_rdata      (reg_rdata),
    .phase_err      (phase_err),
    .phase_loss     (phase_loss),
    .loop_phase_err (loop_phase_err),
    .ref_edge       (ref_edge),
    .ref_period     (ref_period),
    .edge_accept    (edge_accept),
    .edge_reject    (edge_reject),
    .wide_range_en  (wide_range_en)
  );

  // free-running clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    if (failures == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // a write is taken on the edge that sees reg_wr high
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask : reg_write

  // read data lands on the taking edge, so look just after it
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // hold the error two edges so the registered outputs have settled
  task automatic drive_err(input int v);
    @(posedge clk);
    phase_err <= 24'(v);
    @(posedge clk);
    @(posedge clk);
    #1;
  endtask : drive_err

  // gap idle cycles, then a one-cycle edge pulse; verdict shows one cycle later
  task automatic pulse(input int gap, input logic acc);
    repeat (gap) @(posedge clk);
    ref_edge <= 1'b1;
    @(posedge clk);
    ref_edge <= 1'b0;
    #1;
    check("edge_accept", {23'h0, edge_accept}, {23'h0, acc});
    check("edge_reject", {23'h0, edge_reject}, {23'h0, ~acc});
  endtask : pulse

  // hang guard, well above the roughly 650 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  initial begin
    logic [7:0] rd;
    failures = 0; checks_done = 0; cycles = 0;
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 7'h00; reg_wdata = 8'h00;
    phase_err = 24'h000000; ref_edge = 1'b0; ref_period = 16'h0064;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(COARSE_LIMIT_ADDR, rd); check("coarse reset", {16'h0, rd}, 24'h0000e5);
    check("wide_range_en", {23'h0, wide_range_en}, 24'h000001);
    reg_read(NOISE_WINDOW_ADDR, rd); check("noise reset", {16'h0, rd}, 24'h000006);
    reg_read(7'h10, rd); check("unmapped read", {16'h0, rd}, 24'h000000);
    // default limit of 63 UI: 63 UI is inside, one step more is a loss
    drive_err(63 * 256); check("loss default in", {23'h0, phase_loss}, 24'h0);
    drive_err(64 * 256); check("loss default out", {23'h0, phase_loss}, 24'h1);
    // screening on, 100-cycle period: anchor, on time, early, on time again, 5 cycles late (kept), 6 early (dropped)
    reg_write(NOISE_WINDOW_ADDR, 8'h80);
    pulse(5, 1'b1);
    pulse(99, 1'b1);
    pulse(49, 1'b0);
    pulse(49, 1'b1);
    pulse(104, 1'b1);
    pulse(93, 1'b0);
    // screening off: an edge far off schedule still counts
    reg_write(NOISE_WINDOW_ADDR, 8'h7f);
    reg_read(NOISE_WINDOW_ADDR, rd); check("noise rw", {16'h0, rd}, 24'h00007f);
    pulse(30, 1'b1);
    // every coarse code at its boundary, both signs
    for (int c = 0; c < 16; c++) begin
      lim = (c > 11) ? 8191 : ((2 << c) - 1);
      reg_write(COARSE_LIMIT_ADDR, {4'h8, 4'(c)});
      drive_err(lim * 256); check("loss at limit", {23'h0, phase_loss}, 24'h0);
      drive_err(lim * 256 + 1); check("loss past limit", {23'h0, phase_loss}, 24'h1);
      drive_err(-(lim * 256 + 1)); check("loss negative", {23'h0, phase_loss}, 24'h1);
    end
    // coarse detector disabled: no loss however large the error
    reg_write(COARSE_LIMIT_ADDR, 8'h00);
    check("wide_range_en off", {23'h0, wide_range_en}, 24'h0);
    drive_err(9000 * 256); check("loss disabled", {23'h0, phase_loss}, 24'h0);
    // single-cycle response clamps to one UI either way
    check("clamp pos", loop_phase_err, 24'(256));
    drive_err(-5 * 256); check("clamp neg", loop_phase_err, 24'(-256));
    // multi-cycle response passes the coarse result up to 8191 UI
    reg_write(COARSE_LIMIT_ADDR, 8'h60);
    drive_err(-5 * 256); check("multi pass", loop_phase_err, 24'(-5 * 256));
    drive_err(9000 * 256); check("multi sat", loop_phase_err, 24'(8191 * 256));
    stop_test();
  end
endmodule : tb_digital_tracking_loop_phase_limits
